// file: hdl/tlb_bulk_invalidate.sv
// Translation buffer with bulk invalidate walker and an APB register slave.
// Assumes one clock, synchronous active-low reset, a single-master APB bus.
`timescale 1ns/1ps
`include "tlb_bulk_invalidate_regs.svh"

module tlb_bulk_invalidate
  import tlb_bulk_invalidate_pkg::*;
#(
  parameter int VARIABLE_PAGE_ARRAY_N = 16,
  parameter int SETS = 4,
  parameter int WAYS = 2,
  parameter logic [1:0] INV_SUPPORT = `IE_HW_WALK
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lookup_valid,
  input wire logic [18:0] lookup_virtual_page_pair_number,
  output logic lookup_ready,
  output logic lookup_done,
  output logic lookup_hit,
  output logic [7:0] lookup_index,
  output logic busy,
  output logic cop_unusable_exc,
  output logic reserved_instr_exc
);

  localparam int TOTAL = VARIABLE_PAGE_ARRAY_N + SETS * WAYS;
  localparam int IDX_W = $clog2(TOTAL);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    virtual_page_pair_number_t virtual_page_pair_number;
    asid_t asid;
    logic global_flag;
    logic entry_invalid_flag;
  } entry_s;

  typedef struct packed {
    entry_s [TOTAL-1:0] tlb;
    walk_state_e st;
    op_kind_e op;
    logic [IDX_W-1:0] cursor;
    logic [IDX_W-1:0] last;
    logic cop_en;
    logic [2:0] mmu_type_field;
    asid_t eh_asid;
    virtual_page_pair_number_t eh_virtual_page_pair_number;
    logic [IDX_W-1:0] index;
    logic cu_flag;
    logic ri_flag;
    logic cu_pulse;
    logic ri_pulse;
    logic [31:0] rdata;
    logic hit;
    logic done;
    logic [IDX_W-1:0] hit_idx;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic setup;
  logic access;
  logic wr_done;
  logic mapped;
  logic [31:0] rd_mux;
  logic dec_asid;
  logic dec_flush;
  logic [IDX_W-1:0] rng_first;
  logic [IDX_W-1:0] rng_last;
  logic rng_ok;
  logic [1:0] inv_support_field;
  logic [31:0] fourth_config_reg;
  logic [IDX_W-1:0] lk_idx;
  logic lk_hit;

  // Identifier match that honours the global flag
  function automatic logic asid_hits(entry_s e, asid_t a);
    return (e.asid == a) && !e.global_flag;
  endfunction

  // Address decode for the error answer; the read mux decodes paddr itself
  function automatic logic is_mapped(logic [7:0] a);
    return (a == `OFS_CONTROL) || (a == `OFS_ENTRY_HIGH) || (a == `OFS_INDEX) ||
           (a == `OFS_FOURTH_CONFIG) || (a == `OFS_OPERATION) || (a == `OFS_STATUS) ||
           (a == `OFS_ENTRY_WRITE) || (a == `OFS_ENTRY_READ);
  endfunction

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  tlb_op_decode u_decode (
    .instr(pwdata),
    .is_asid_inv(dec_asid),
    .is_flush_inv(dec_flush)
  );

  tlb_range_select #(
    .VARIABLE_PAGE_ARRAY_N(VARIABLE_PAGE_ARRAY_N),
    .SETS(SETS),
    .WAYS(WAYS),
    .IDX_W(IDX_W)
  ) u_range (
    .mmu_type(s_q.mmu_type_field),
    .inv_support(inv_support_field),
    .index(s_q.index),
    .first(rng_first),
    .last(rng_last),
    .in_range(rng_ok)
  );

  // ----------------------------------------------------------------
  // Bus handshake and read data
  // ----------------------------------------------------------------
  // Fixed support level, reported to software
  always_comb begin
    inv_support_field = INV_SUPPORT;
    fourth_config_reg = 32'h0;
    fourth_config_reg[1:0] = inv_support_field;
    fourth_config_reg[`CFG4_SETS_LSB +: 8] = 8'(SETS);
    fourth_config_reg[`CFG4_WAYS_LSB +: 8] = 8'(WAYS);
    fourth_config_reg[`CFG4_SIZE_LSB +: 8] = 8'(VARIABLE_PAGE_ARRAY_N - 1);
  end

  // Every access waits while a walk runs
  always_comb begin
    setup = psel && !penable;
    access = psel && penable;
    pready = (s_q.st == ST_IDLE);
    wr_done = access && pready && pwrite;
    mapped = is_mapped(paddr);
    pslverr = access && pready && !mapped;
    prdata = s_q.rdata;
  end

  // Read mux over the register map
  always_comb begin
    entry_s e;
    e = s_q.tlb[s_q.index];
    rd_mux = 32'h0;
    case (paddr)
      `OFS_CONTROL: begin
        rd_mux[`CTRL_COP_EN_BIT] = s_q.cop_en;
        rd_mux[`CTRL_MT_LSB +: 3] = s_q.mmu_type_field;
      end
      `OFS_ENTRY_HIGH: begin
        rd_mux[7:0] = s_q.eh_asid;
        rd_mux[`EH_VIRTUAL_PAGE_PAIR_NUMBER_LSB +: 19] = s_q.eh_virtual_page_pair_number;
      end
      `OFS_INDEX: rd_mux[IDX_W-1:0] = s_q.index;
      `OFS_FOURTH_CONFIG: rd_mux = fourth_config_reg;
      `OFS_STATUS: begin
        rd_mux[`STAT_BUSY_BIT] = (s_q.st == ST_WALK);
        rd_mux[`STAT_CU_BIT] = s_q.cu_flag;
        rd_mux[`STAT_RI_BIT] = s_q.ri_flag;
      end
      `OFS_ENTRY_READ: begin
        rd_mux[7:0] = e.asid;
        rd_mux[`ER_VIRTUAL_PAGE_PAIR_NUMBER_LSB +: 19] = e.virtual_page_pair_number;
        rd_mux[`ER_GLOBAL_BIT] = e.global_flag;
        rd_mux[`ER_INVALID_BIT] = e.entry_invalid_flag;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  // Fully associative compare; invalid entries never hit
  always_comb begin
    lk_hit = 1'b0;
    lk_idx = '0;
    for (int i = 0; i < TOTAL; i++) begin
      if (!s_q.tlb[i].entry_invalid_flag &&
          (s_q.tlb[i].virtual_page_pair_number == lookup_virtual_page_pair_number) &&
          (s_q.tlb[i].global_flag || (s_q.tlb[i].asid == s_q.eh_asid)) && !lk_hit) begin
        lk_hit = 1'b1;
        lk_idx = IDX_W'(i);
      end
    end
  end

  // Outputs straight from state
  always_comb begin
    lookup_ready = (s_q.st == ST_IDLE);
    lookup_done = s_q.done;
    lookup_hit = s_q.hit;
    lookup_index = 8'(s_q.hit_idx);
    busy = (s_q.st == ST_WALK);
    cop_unusable_exc = s_q.cu_pulse;
    reserved_instr_exc = s_q.ri_pulse;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cu_pulse = 1'b0;
    s_d.ri_pulse = 1'b0;
    s_d.done = 1'b0;
    if (psel) begin
      s_d.rdata = rd_mux;
    end

    // Lookups only while the array is settled
    if (lookup_valid && lookup_ready) begin
      s_d.done = 1'b1;
      s_d.hit = lk_hit;
      s_d.hit_idx = lk_idx;
    end

    // Walker: one entry per cycle across the whole chosen range
    if (s_q.st == ST_WALK) begin
      if (s_q.op == OP_FLUSH) begin
        s_d.tlb[s_q.cursor].entry_invalid_flag = 1'b1;
      end else if (asid_hits(s_q.tlb[s_q.cursor], s_q.eh_asid)) begin
        s_d.tlb[s_q.cursor].entry_invalid_flag = 1'b1;
      end
      if (s_q.cursor == s_q.last) begin
        s_d.st = ST_IDLE;
      end else begin
        s_d.cursor = s_q.cursor + 1'b1;
      end
    end

    // Register writes at the completing access edge
    if (wr_done) begin
      case (paddr)
        `OFS_CONTROL: begin
          s_d.cop_en = pwdata[`CTRL_COP_EN_BIT];
          s_d.mmu_type_field = pwdata[`CTRL_MT_LSB +: 3];
        end
        `OFS_ENTRY_HIGH: begin
          s_d.eh_asid = pwdata[7:0];
          s_d.eh_virtual_page_pair_number = pwdata[`EH_VIRTUAL_PAGE_PAIR_NUMBER_LSB +: 19];
        end
        `OFS_INDEX: s_d.index = pwdata[IDX_W-1:0];
        `OFS_STATUS: begin
          s_d.cu_flag = s_q.cu_flag && !pwdata[`STAT_CU_BIT];
          s_d.ri_flag = s_q.ri_flag && !pwdata[`STAT_RI_BIT];
        end
        `OFS_ENTRY_WRITE: begin
          s_d.tlb[s_q.index].asid = s_q.eh_asid;
          s_d.tlb[s_q.index].virtual_page_pair_number = s_q.eh_virtual_page_pair_number;
          s_d.tlb[s_q.index].global_flag = pwdata[`EW_GLOBAL_BIT];
          s_d.tlb[s_q.index].entry_invalid_flag = pwdata[`EW_INVALID_BIT];
        end
        `OFS_OPERATION: begin
          if (!(dec_asid || dec_flush) || (inv_support_field < `IE_SW_WALK)) begin
            s_d.ri_pulse = 1'b1;
          end else if (!s_q.cop_en) begin
            s_d.cu_pulse = 1'b1;
          end else if (rng_ok) begin
            s_d.st = ST_WALK;
            s_d.op = dec_flush ? OP_FLUSH : OP_ASID;
            s_d.cursor = rng_first;
            s_d.last = rng_last;
          end
        end
        default: s_d.cu_pulse = 1'b0;
      endcase
    end

    // Sticky error flags: a new event beats a clear in the same cycle
    if (s_d.cu_pulse) begin
      s_d.cu_flag = 1'b1;
    end
    if (s_d.ri_pulse) begin
      s_d.ri_flag = 1'b1;
    end

    // Synchronous reset: every entry invalid, joint array mode
    if (!reset_n) begin
      s_d = '0;
      s_d.mmu_type_field = `MT_RESET;
      for (int i = 0; i < TOTAL; i++) begin
        s_d.tlb[i].entry_invalid_flag = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

endmodule

// file: hdl/tlb_op_decode.sv
// Decoder for the two bulk TLB maintenance instruction words.
// Assumes a full 32-bit instruction word is presented.
`timescale 1ns/1ps
`include "tlb_bulk_invalidate_regs.svh"

module tlb_op_decode
  import tlb_bulk_invalidate_pkg::*;
(
  input wire logic [31:0] instr,
  output logic is_asid_inv,
  output logic is_flush_inv
);

  logic common;

  // Major opcode, coprocessor-operation bit and zero middle field
  always_comb begin
    common = (instr[31:26] == `OPC_SYS_COP) && instr[25] && (instr[24:6] == 19'h00000);
    is_asid_inv = common && (instr[5:0] == `FUNC_ASID_INV);
    is_flush_inv = common && (instr[5:0] == `FUNC_FLUSH_INV);
  end

endmodule

// file: hdl/tlb_range_select.sv
// Works out the first and last entry that a bulk invalidate walks.
// Assumes entries are laid out variable-page first, then fixed sets way by way.
`timescale 1ns/1ps
`include "tlb_bulk_invalidate_regs.svh"

module tlb_range_select
  import tlb_bulk_invalidate_pkg::*;
#(
  parameter int VARIABLE_PAGE_ARRAY_N = 16,
  parameter int SETS = 4,
  parameter int WAYS = 2,
  parameter int IDX_W = 5
) (
  input wire logic [2:0] mmu_type,
  input wire logic [1:0] inv_support,
  input wire logic [IDX_W-1:0] index,
  output logic [IDX_W-1:0] first,
  output logic [IDX_W-1:0] last,
  output logic in_range
);

  localparam int TOTAL = VARIABLE_PAGE_ARRAY_N + SETS * WAYS;

  // Range decision by MMU type, walk style and index
  always_comb begin
    int base;
    base = 0;
    first = '0;
    last = IDX_W'(TOTAL - 1);
    in_range = 1'b0;
    if (mmu_type == `MT_JOINT) begin
      in_range = 1'b1;
    end else if (mmu_type == `MT_SPLIT) begin
      if (inv_support == `IE_HW_WALK) begin
        in_range = 1'b1;
      end else if (inv_support == `IE_SW_WALK) begin
        in_range = 1'b1;
        if (int'(index) < VARIABLE_PAGE_ARRAY_N) begin
          last = IDX_W'(VARIABLE_PAGE_ARRAY_N - 1);
        end else begin
          base = VARIABLE_PAGE_ARRAY_N + ((int'(index) - VARIABLE_PAGE_ARRAY_N) / WAYS) * WAYS;
          first = IDX_W'(base);
          last = IDX_W'(base + WAYS - 1);
        end
      end
    end
  end

endmodule

// file: inc/tlb_bulk_invalidate_pkg.sv
// Types shared by the bulk invalidate design files.
// Assumes nothing beyond a SystemVerilog compiler.
package tlb_bulk_invalidate_pkg;

  // Walker states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WALK = 1'b1
  } walk_state_e;

  // Kind of bulk operation in flight
  typedef enum logic [0:0] {
    OP_ASID = 1'b0,
    OP_FLUSH = 1'b1
  } op_kind_e;

  typedef logic [7:0] asid_t;
  typedef logic [18:0] virtual_page_pair_number_t;

endpackage

// file: inc/tlb_bulk_invalidate_regs.svh
// Offsets, field positions, reset values and opcode codes of the bulk invalidate block.
// Assumes byte addresses on a 32-bit APB bus, one aligned word per register.
`ifndef TLB_BULK_INVALIDATE_REGS_SVH
`define TLB_BULK_INVALIDATE_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_ENTRY_HIGH 8'h04
`define OFS_INDEX 8'h08
`define OFS_FOURTH_CONFIG 8'h0c
`define OFS_OPERATION 8'h10
`define OFS_STATUS 8'h14
`define OFS_ENTRY_WRITE 8'h18
`define OFS_ENTRY_READ 8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_COP_EN_BIT 0
`define CTRL_MT_LSB 4
`define EH_VIRTUAL_PAGE_PAIR_NUMBER_LSB 13
`define STAT_BUSY_BIT 0
`define STAT_CU_BIT 1
`define STAT_RI_BIT 2
`define EW_GLOBAL_BIT 0
`define EW_INVALID_BIT 1
`define ER_INVALID_BIT 31
`define ER_GLOBAL_BIT 30
`define ER_VIRTUAL_PAGE_PAIR_NUMBER_LSB 8
`define CFG4_SETS_LSB 8
`define CFG4_WAYS_LSB 16
`define CFG4_SIZE_LSB 24

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define MT_JOINT 3'h1
`define MT_SPLIT 3'h4
`define MT_RESET 3'h1
`define IE_SW_WALK 2'h2
`define IE_HW_WALK 2'h3

// ----------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------
`define OPC_SYS_COP 6'h10
`define FUNC_ASID_INV 6'h03
`define FUNC_FLUSH_INV 6'h04

`endif

// file: tb/cpu_model.sv
// Pipeline model: issues register and maintenance accesses as an APB master.
// Assumes the slave answers through pready; idle lines show inverted data.
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One transfer, held until pready is seen high at a rising edge; gives up after 100 cycles
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output bit to);
    int n;
    to = 1;
    rd = 32'h00000000;
    err = 1'b0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 100 && to; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        to = 0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// file: tb/tb_tlb_bulk_invalidate.sv
// Self-checking bench: fills the array, runs bulk operations, reads back.
// Assumes the block built with software walk and default array sizes.
`timescale 1ns/1ps
`include "tlb_bulk_invalidate_regs.svh"
module tb_tlb_bulk_invalidate;
  import tlb_bulk_invalidate_pkg::*;
  localparam int VN = 16, ST = 4, WY = 2, NE = 24;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic lookup_valid, lookup_ready, lookup_done, lookup_hit;
  logic busy, cop_unusable_exc, reserved_instr_exc;
  logic [18:0] lookup_virtual_page_pair_number;
  logic [7:0] lookup_index;
  logic [7:0] m_asid [NE];
  logic [18:0] m_vpn [NE];
  logic m_g [NE];
  logic m_inv [NE];
  int mismatches, tests_run, s;
  tlb_bulk_invalidate #(.VARIABLE_PAGE_ARRAY_N(VN), .SETS(ST), .WAYS(WY), .INV_SUPPORT(`IE_SW_WALK)) u_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lookup_valid(lookup_valid), .lookup_virtual_page_pair_number(lookup_virtual_page_pair_number), .lookup_ready(lookup_ready),
    .lookup_done(lookup_done), .lookup_hit(lookup_hit), .lookup_index(lookup_index),
    .busy(busy), .cop_unusable_exc(cop_unusable_exc), .reserved_instr_exc(reserved_instr_exc));
  cpu_model u_cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  // Bus access with timeout handling
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd, output logic err);
    bit to;
    u_cpu.xfer(w, a, d, rd, err, to);
    if (to) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    xf(1'b1, a, d, rd, err);
  endtask
  // Lookup issued during a walk; expects the first live matching entry
  task automatic look(input logic [18:0] v);
    int n, i, ei;
    logic eh;
    eh = 1'b0;
    ei = 0;
    for (i = NE - 1; i >= 0; i--) begin
      if (!m_inv[i] && m_vpn[i] == v && (m_g[i] || m_asid[i] == 8'h01)) begin
        eh = 1'b1;
        ei = i;
      end
    end
    @(posedge clk);
    lookup_valid <= 1'b1;
    lookup_virtual_page_pair_number <= v;
    n = 0;
    // Request held until a rising edge that samples ready high takes it
    do begin
      @(posedge clk);
      n++;
    end while (lookup_ready !== 1'b1 && n < 100);
    if (lookup_ready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    lookup_valid <= 1'b0;
    lookup_virtual_page_pair_number <= ~v;
    @(negedge clk);
    chk("done", 32'h1, {31'h0, lookup_done});
    chk("hit", {31'h0, eh}, {31'h0, lookup_hit});
    if (eh) chk("index", ei, {24'h0, lookup_index});
  endtask
  // Optional refill, one bulk operation, then full readback
  task automatic run(input logic [2:0] mt, input logic [5:0] fn, input int idx, input bit fill);
    int i, lo, hi;
    logic [31:0] rd;
    logic err;
    for (i = 0; i < NE && fill; i++) begin
      rnd = lfsr(rnd);
      m_asid[i] = {7'h00, rnd[0]} + 8'h01;
      m_vpn[i] = {17'h00000, rnd[2:1]};
      m_g[i] = rnd[3];
      m_inv[i] = 1'b0;
      wr(`OFS_INDEX, i);
      wr(`OFS_ENTRY_HIGH, {m_vpn[i], 5'h00, m_asid[i]});
      wr(`OFS_ENTRY_WRITE, {31'h0, m_g[i]});
    end
    wr(`OFS_CONTROL, {25'h0, mt, 3'h0, 1'b1});
    wr(`OFS_ENTRY_HIGH, {rnd[31:13], 5'h00, 8'h01});
    wr(`OFS_INDEX, idx);
    wr(`OFS_OPERATION, {`OPC_SYS_COP, 1'b1, 19'h0, fn});
    @(negedge clk);
    chk("busy", 32'h1, {31'h0, busy});
    chk("walk exc", 32'h0, {30'h0, cop_unusable_exc, reserved_instr_exc});
    lo = 0;
    hi = NE - 1;
    if (mt == `MT_SPLIT && idx >= VN) begin
      lo = VN + (idx - VN) / WY * WY;
      hi = lo + WY - 1;
    end else if (mt == `MT_SPLIT) hi = VN - 1;
    for (i = lo; i <= hi; i++) begin
      if (fn == `FUNC_FLUSH_INV || (m_asid[i] == 8'h01 && !m_g[i])) m_inv[i] = 1'b1;
    end
    look(m_vpn[0]);
    for (i = 0; i < NE; i++) begin
      wr(`OFS_INDEX, i);
      xf(1'b0, `OFS_ENTRY_READ, 32'h0, rd, err);
      if (m_inv[i]) chk("invalid", 32'h1, {31'h0, rd[31]});
      else chk("entry", {1'b0, m_g[i], 3'h0, m_vpn[i], m_asid[i]}, rd);
    end
    $display("case mt %0d fn %0h idx %0d done", mt, fn, idx);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    logic [31:0] rd;
    logic err;
    mismatches = 0;
    tests_run = 0;
    rnd = 32'h000163cf;
    reset_n = 1'b0;
    lookup_valid = 1'b0;
    lookup_virtual_page_pair_number = 19'h00000;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    xf(1'b0, `OFS_FOURTH_CONFIG, 32'h0, rd, err);
    chk("config", {8'(VN - 1), 8'(WY), 8'(ST), 6'h00, `IE_SW_WALK}, rd);
    xf(1'b0, 8'h20, 32'h0, rd, err);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    wr(`OFS_OPERATION, {`OPC_SYS_COP, 1'b1, 19'h0, `FUNC_ASID_INV});
    @(negedge clk);
    chk("cop pulse", 32'h1, {31'h0, cop_unusable_exc});
    xf(1'b0, `OFS_STATUS, 32'h0, rd, err);
    chk("cop status", 32'h2, rd & 32'h7);
    wr(`OFS_CONTROL, {25'h0, `MT_JOINT, 3'h0, 1'b1});
    for (s = 0; s < 2; s++) begin
      wr(`OFS_STATUS, 32'h7);
      wr(`OFS_OPERATION, {`OPC_SYS_COP, 1'b1, 19'(s), 6'h05 - 6'(s * 2)});
      @(negedge clk);
      chk("ri pulse", 32'h1, {31'h0, reserved_instr_exc});
      xf(1'b0, `OFS_STATUS, 32'h0, rd, err);
      chk("ri status", 32'h4, rd & 32'h7);
    end
    $display("exception cases done");
    run(`MT_JOINT, `FUNC_ASID_INV, 20, 1);
    run(`MT_SPLIT, `FUNC_ASID_INV, 3, 1);
    run(`MT_SPLIT, `FUNC_ASID_INV, 19, 1);
    run(`MT_JOINT, `FUNC_FLUSH_INV, 5, 1);
    run(`MT_SPLIT, `FUNC_FLUSH_INV, 0, 1);
    run(`MT_SPLIT, `FUNC_FLUSH_INV, 23, 1);
    run(`MT_SPLIT, `FUNC_ASID_INV, 0, 1);
    for (s = 0; s < ST; s++) run(`MT_SPLIT, `FUNC_ASID_INV, VN + s * WY, 0);
    wrap_up();
  end
endmodule
bind tlb_bulk_invalidate tlb_bulk_invalidate_sva #(.VARIABLE_PAGE_ARRAY_N(VARIABLE_PAGE_ARRAY_N), .SETS(SETS), .WAYS(WAYS)) u_sva (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lookup_valid(lookup_valid), .lookup_virtual_page_pair_number(lookup_virtual_page_pair_number), .lookup_ready(lookup_ready),
  .lookup_done(lookup_done), .lookup_hit(lookup_hit), .lookup_index(lookup_index),
  .busy(busy), .cop_unusable_exc(cop_unusable_exc), .reserved_instr_exc(reserved_instr_exc));

// file: tb/tlb_bulk_invalidate_sva.sv
// Concurrent checks on the ports of the bulk invalidate block.
// Assumes it is bound to the top module and only watches its ports.
`timescale 1ns/1ps
`include "tlb_bulk_invalidate_regs.svh"
module tlb_bulk_invalidate_sva #(
  parameter int VARIABLE_PAGE_ARRAY_N = 16,
  parameter int SETS = 4,
  parameter int WAYS = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lookup_valid,
  input wire logic [18:0] lookup_virtual_page_pair_number,
  input wire logic lookup_ready,
  input wire logic lookup_done,
  input wire logic lookup_hit,
  input wire logic [7:0] lookup_index,
  input wire logic busy,
  input wire logic cop_unusable_exc,
  input wire logic reserved_instr_exc
);
  localparam int WLIM = VARIABLE_PAGE_ARRAY_N + SETS * WAYS + 1;
  logic op_wr;
  // Completed write to the operation register
  assign op_wr = psel && penable && pready && pwrite && paddr == `OFS_OPERATION;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ready_tracks_busy_a: assert property (pready == !busy && lookup_ready == !busy)
    else $error("ready high during walk");
  walk_bounded_a: assert property ($rose(busy) |-> ##[1:WLIM] !busy)
    else $error("walk too long");
  walk_cause_a: assert property ($rose(busy) |-> $past(op_wr))
    else $error("walk without operation write");
  cop_exc_cause_a: assert property (cop_unusable_exc |-> $past(op_wr) && !busy)
    else $error("stray coprocessor exception");
  ri_exc_cause_a: assert property (reserved_instr_exc |-> $past(op_wr) && !busy)
    else $error("stray reserved exception");
  exc_pulse_a: assert property (cop_unusable_exc || reserved_instr_exc
    |=> !cop_unusable_exc && !reserved_instr_exc)
    else $error("exception longer than a pulse");
  lookup_answer_a: assert property (lookup_valid && lookup_ready |=> lookup_done)
    else $error("lookup not answered");
  done_cause_a: assert property (lookup_done |-> $past(lookup_valid && lookup_ready))
    else $error("stray lookup done");
  hit_hold_a: assert property (!lookup_done |-> $stable(lookup_hit))
    else $error("hit changed without lookup");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule
